// File: src/zcd_dimmer.sv
/*
 * Phase-angle dimmer: zero-cross edge detect, phase delay timer, triac gate
 * pulse pair, intensity ramp, and the millisecond tick timer.
 * Assumes zero-cross inputs already clean and synchronous to clk.
 */
`timescale 1ns/1ps
module zcd_dimmer #(
	parameter int STEP_CYC = zcd_pkg::STEP_CYC,
	parameter int MS_CYC = zcd_pkg::MS_CYC,
	parameter int DW = zcd_pkg::DW,
	parameter int UW = zcd_pkg::UW
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic [3:0] zc_in, // Edge inputs four to seven
	input wire logic [1:0] zc_sel,
	input wire logic dim_on,
	input wire logic [DW-1:0] intensity,
	input wire logic ms_start,
	input wire logic [UW-1:0] ms_units,
	output logic triac_gate,
	output logic keypad_edge_interrupt,
	output logic phase_delay_irq,
	output logic [DW-1:0] firing_delay,
	output logic ms_busy,
	output logic ms_done,
	output logic ms_wrap_flag
);
	localparam int PW = $clog2(STEP_CYC);
	zcd_pkg::zcd_state_e st_q, st_d;
	logic [3:0] zc_prev_q, rise;
	logic [PW-1:0] pre_q, pre_d;
	logic [DW-1:0] cnt_q, cnt_d, mod, dly_q, dly_d, tgt;
	logic kei_q, kei_d, irq_q, irq_d, gate_q, gate_d, evt, tick, wrap;

	// Rising edge per input; only these four can detect rising edges
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_edge
			assign rise[gi] = zc_in[gi] && !zc_prev_q[gi];
		end
	endgenerate
	assign evt = rise[zc_sel];

	// Intensity to target delay; high intensity means early firing
	assign tgt = (intensity >= zcd_pkg::MAX_DELAY) ? '0 : zcd_pkg::MAX_DELAY - intensity;

	// Modulo per phase; gap ends one half period after the first pulse starts
	always_comb begin
		unique case (st_q)
			zcd_pkg::ST_DELAY: mod = dly_q;
			zcd_pkg::ST_GAP: mod = zcd_pkg::HALF_STEPS - zcd_pkg::PULSE_STEPS - DW'(1);
			default: mod = zcd_pkg::PULSE_STEPS - DW'(1);
		endcase
	end
	assign tick = (st_q != zcd_pkg::ST_IDLE) && (pre_q == PW'(STEP_CYC - 1));
	assign wrap = tick && (cnt_q == mod);

	// Ramp: one bounded step per zero crossing avoids visible flicker
	always_comb begin
		dly_d = dly_q;
		if (evt && dim_on) begin
			if (tgt > dly_q) begin
				dly_d = (tgt - dly_q > zcd_pkg::RAMP_STEP) ? dly_q + zcd_pkg::RAMP_STEP : tgt;
			end else if (tgt < dly_q) begin
				dly_d = (dly_q - tgt > zcd_pkg::RAMP_STEP) ? dly_q - zcd_pkg::RAMP_STEP : tgt;
			end
		end
	end

	// Phase timer and firing sequence; a new crossing resynchronises while dim_on is high
	always_comb begin
		st_d = st_q;
		pre_d = pre_q;
		cnt_d = cnt_q;
		irq_d = 1'b0;
		kei_d = evt;
		if (!dim_on) begin
			st_d = zcd_pkg::ST_IDLE;
			pre_d = '0;
			cnt_d = '0;
		end else if (evt) begin
			st_d = zcd_pkg::ST_DELAY;
			pre_d = '0;
			cnt_d = '0;
		end else if (st_q != zcd_pkg::ST_IDLE) begin
			pre_d = tick ? '0 : pre_q + PW'(1);
			if (wrap) begin
				cnt_d = '0;
				irq_d = 1'b1;
				unique case (st_q)
					zcd_pkg::ST_DELAY: st_d = zcd_pkg::ST_PULSE1;
					zcd_pkg::ST_PULSE1: st_d = zcd_pkg::ST_GAP;
					zcd_pkg::ST_GAP: st_d = zcd_pkg::ST_PULSE2;
					zcd_pkg::ST_PULSE2: st_d = zcd_pkg::ST_IDLE;
					default: st_d = zcd_pkg::ST_IDLE;
				endcase
			end else if (tick) begin
				cnt_d = cnt_q + DW'(1);
			end
		end
		// Two distinct pulses, only inside a crossing-started cycle
		gate_d = (st_d == zcd_pkg::ST_PULSE1) || (st_d == zcd_pkg::ST_PULSE2);
	end

	// Registers, frozen while en is low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= zcd_pkg::ST_IDLE;
			zc_prev_q <= '0;
			pre_q <= '0;
			cnt_q <= '0;
			dly_q <= zcd_pkg::DELAY_RST;
			kei_q <= 1'b0;
			irq_q <= 1'b0;
			gate_q <= 1'b0;
		end else if (en) begin
			st_q <= st_d;
			zc_prev_q <= zc_in;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			dly_q <= dly_d;
			kei_q <= kei_d;
			irq_q <= irq_d;
			gate_q <= gate_d;
		end
	end

	assign triac_gate = gate_q;
	assign keypad_edge_interrupt = kei_q;
	assign phase_delay_irq = irq_q;
	assign firing_delay = dly_q;

	// Blocking millisecond delays
	zcd_ms_timer #(
		.MS_CYC(MS_CYC),
		.UW(UW)
	) u_ms (
		.clk(clk),
		.rstn(rstn),
		.en(en),
		.start(ms_start),
		.units(ms_units),
		.busy(ms_busy),
		.done(ms_done),
		.wrap_flag(ms_wrap_flag)
	);

	// Helper: gate rising edges since the last crossing, saturating at three
	logic [1:0] npulse_q, npulse_d;
	always_comb begin
		npulse_d = npulse_q;
		if (evt) begin
			npulse_d = 2'h0;
		end else if (gate_d && !gate_q && npulse_q != 2'h3) begin
			npulse_d = npulse_q + 2'h1;
		end
	end

	// Helper register, frozen with the rest
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			npulse_q <= '0;
		end else if (en) begin
			npulse_q <= npulse_d;
		end
	end

	property p_edge_irq;
		@(posedge clk) disable iff (!rstn)
		en && evt |=> keypad_edge_interrupt;
	endproperty
	a_edge_irq: assert property (p_edge_irq) else $error("Edge interrupt missed");

	property p_sel_only;
		@(posedge clk) disable iff (!rstn)
		en && !evt |=> !keypad_edge_interrupt;
	endproperty
	a_sel_only: assert property (p_sel_only) else $error("Interrupt without selected edge");

	property p_start;
		@(posedge clk) disable iff (!rstn)
		en && evt && dim_on |=> st_q == zcd_pkg::ST_DELAY && cnt_q == '0;
	endproperty
	a_start: assert property (p_start) else $error("Delay not started on edge");

	property p_wrap;
		@(posedge clk) disable iff (!rstn)
		en && wrap && dim_on && !evt |=> phase_delay_irq && cnt_q == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Wrap did not raise phase interrupt");

	property p_two_pulses;
		@(posedge clk) disable iff (!rstn)
		npulse_q <= 2'h2;
	endproperty
	a_two_pulses: assert property (p_two_pulses) else $error("More than two gate pulses");

	sequence s_gate_rise;
		$rose(triac_gate);
	endsequence
	property p_pulse_timed;
		@(posedge clk) disable iff (!rstn)
		s_gate_rise |-> phase_delay_irq || $past(evt);
	endproperty
	a_pulse_timed: assert property (p_pulse_timed) else $error("Gate pulse not timer-timed");

	property p_ramp;
		@(posedge clk) disable iff (!rstn)
		!$stable(dly_q) |-> ((dly_q > $past(dly_q)) ? dly_q - $past(dly_q) : $past(dly_q) - dly_q) <= zcd_pkg::RAMP_STEP;
	endproperty
	a_ramp: assert property (p_ramp) else $error("Firing delay jumped");

	property p_off;
		@(posedge clk) disable iff (!rstn)
		en && !dim_on |=> !triac_gate && st_q == zcd_pkg::ST_IDLE;
	endproperty
	a_off: assert property (p_off) else $error("Firing while dimming off");

	// A pulse ends on a timer wrap, a resync or a switch-off, never on its own
	sequence s_gate_fall;
		$fell(triac_gate);
	endsequence
	property p_pulse_end;
		@(posedge clk) disable iff (!rstn)
		s_gate_fall |-> phase_delay_irq || $past(evt) || !$past(dim_on);
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("Gate pulse not ended by timer");

	// Low enable must hold every piece of firing state
	property p_freeze;
		@(posedge clk) disable iff (!rstn)
		!en |=> $stable(st_q) && $stable(cnt_q) && $stable(pre_q) && $stable(dly_q) && $stable(triac_gate);
	endproperty
	a_freeze: assert property (p_freeze) else $error("Firing state moved while enable low");
endmodule : zcd_dimmer

// File: src/zcd_pkg.sv
/*
 * Constants, timing counts and state codes of the zero-cross phase dimmer.
 * Assumes a single 250 MHz clock and zero-cross pulses synchronous to it.
 */
// What this block does
// - Zero-cross rising edge raises edge interrupt, starts cycle
// - Rising-edge detection only on edge inputs four to seven
// - Each firing is two separate gate pulses
// - Edge event starts phase delay from intensity
// - Wrap flag sets when counter reaches modulo
// - Phase timer interrupts on wrap, ending delay
// - Two pulses in successive half periods, timer-timed
// - Intensity changes ramp the delay gradually
// - Tick timer gives delays in whole milliseconds
// - Tick timer polled by wrap flag, no interrupt
// - All gate firing synchronised to zero crossings
package zcd_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MS_TIME_NS = 1_000_000;
	localparam int MS_CYC = (MS_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int STEP_TIME_NS = 10_000;
	localparam int STEP_CYC = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int DW = 10;
	localparam int UW = 16;
	// Counts below are in phase steps of STEP_TIME_NS
	localparam logic [9:0] HALF_STEPS = 10'h03E8;
	localparam logic [9:0] PULSE_STEPS = 10'h000A;
	localparam logic [9:0] MAX_DELAY = 10'h03D4;
	localparam logic [9:0] RAMP_STEP = 10'h0004;
	localparam logic [9:0] DELAY_RST = 10'h03D4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DELAY = 3'b001,
		ST_PULSE1 = 3'b010,
		ST_GAP = 3'b011,
		ST_PULSE2 = 3'b100
	} zcd_state_e;
endpackage : zcd_pkg

// File: src/zcd_ms_timer.sv
/*
 * Millisecond tick timer: a blocking delay of whole 1 ms units.
 * Assumes start and units are synchronous to clk and held stable while busy.
 */
`timescale 1ns/1ps
module zcd_ms_timer #(
	parameter int MS_CYC = zcd_pkg::MS_CYC,
	parameter int UW = zcd_pkg::UW
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic start,
	input wire logic [UW-1:0] units,
	output logic busy,
	output logic done,
	output logic wrap_flag
);
	localparam int PW = $clog2(MS_CYC);
	logic [PW-1:0] pre_q, pre_d;
	logic [UW-1:0] cnt_q, cnt_d, mod;
	logic busy_q, busy_d, flag_q, flag_d, done_q, done_d, tick;

	// Modulo: units-1 so that N gives N whole ticks; zero acts as one
	assign mod = (units == '0) ? '0 : units - UW'(1);
	assign tick = busy_q && (pre_q == PW'(MS_CYC - 1));

	// Next state; the wait logic polls the wrap flag instead of an interrupt
	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		flag_d = flag_q;
		done_d = 1'b0;
		if (start && !busy_q) begin
			pre_d = '0;
			cnt_d = '0;
			busy_d = 1'b1;
			flag_d = 1'b0;
		end else if (busy_q && flag_q) begin
			busy_d = 1'b0;
			done_d = 1'b1;
		end else if (busy_q) begin
			pre_d = tick ? '0 : pre_q + PW'(1);
			if (tick) begin
				if (cnt_q == mod) begin
					cnt_d = '0;
					flag_d = 1'b1;
				end else begin
					cnt_d = cnt_q + UW'(1);
				end
			end
		end
	end

	// Registers, frozen while en is low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			flag_q <= 1'b0;
			done_q <= 1'b0;
		end else if (en) begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			flag_q <= flag_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign wrap_flag = flag_q;

	property p_ms_poll;
		@(posedge clk) disable iff (!rstn)
		en && busy_q && flag_q |=> done_q && !busy_q;
	endproperty
	a_ms_poll: assert property (p_ms_poll) else $error("Polled wrap did not end the delay");

	property p_ms_tick;
		@(posedge clk) disable iff (!rstn)
		$rose(flag_q) |-> $past(tick) && $past(cnt_q) == $past(mod);
	endproperty
	a_ms_tick: assert property (p_ms_tick) else $error("Wrap flag set off a ms tick");
endmodule : zcd_ms_timer

// File: sim/zcd_mains.sv
/*
 * Mains side model: the zero-cross detector feeding the edge inputs.
 * Assumes the bench asks for each crossing and supplies idle-line noise.
 */
`timescale 1ns/1ps
module zcd_mains (
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] sel,
	input wire logic [3:0] noise,
	output logic [3:0] zc_in
);
	logic lvl = 1'b0;
	int hold = 0;
	// Clean rise held 20 cycles per crossing
	always @(posedge clk) begin
		lvl <= go || hold > 1;
		hold <= go ? 20 : (hold > 0 ? hold - 1 : 0);
	end
	// Idle lines chatter, so a wrong source select is seen
	assign zc_in = (noise & ~(4'h1 << sel)) | ({3'h0, lvl} << sel);
endmodule : zcd_mains

// File: sim/zero_cross_phase_dimmer_bench.sv
/*
 * Self-checking bench for the phase dimmer and its tick timer.
 * Assumes short step and tick counts; the mains model makes the crossings.
 */
`timescale 1ns/1ps
module zero_cross_phase_dimmer_bench;
	localparam int S = 4;
	localparam int M = 8;
	logic clk = 1'b0, rstn = 1'b0, en = 1'b1, dim_on = 1'b0, ms_start = 1'b0, go = 1'b0;
	logic [1:0] zc_sel = 2'h0;
	logic [3:0] noise = 4'h0, zc_in;
	logic [9:0] intensity = 10'h0000, firing_delay, dly = 10'h03D4;
	logic [15:0] ms_units = 16'h0001;
	logic triac_gate, kei, pirq, ms_busy, ms_done, ms_wrap_flag, gq = 1'b0;
	int error_cnt = 0, n_tests = 0, seed = 67473, irqs = 0, keis = 0, cyc = 0;
	int rq[$], fq[$];

	zcd_dimmer #(.STEP_CYC(S), .MS_CYC(M)) i_zcd_dimmer (.clk(clk), .rstn(rstn), .en(en), .zc_in(zc_in),
		.zc_sel(zc_sel), .dim_on(dim_on), .intensity(intensity), .ms_start(ms_start), .ms_units(ms_units),
		.triac_gate(triac_gate), .keypad_edge_interrupt(kei), .phase_delay_irq(pirq),
		.firing_delay(firing_delay), .ms_busy(ms_busy), .ms_done(ms_done), .ms_wrap_flag(ms_wrap_flag));
	zcd_mains i_zcd_mains (.clk(clk), .go(go), .sel(zc_sel), .noise(noise), .zc_in(zc_in));

	always #2 clk = ~clk;
	// Fresh noise each cycle on the unselected lines
	always @(negedge clk) noise <= 4'($random(seed));
	// Edge counter; outputs are read on the far edge, where they are settled
	always @(posedge clk) cyc <= cyc + 1;
	// Gate edge times, timer and edge interrupts of the current crossing
	always @(negedge clk) begin
		gq <= triac_gate;
		if (triac_gate === 1'b1 && gq === 1'b0) rq.push_back(cyc);
		if (triac_gate === 1'b0 && gq === 1'b1) fq.push_back(cyc);
		if (pirq === 1'b1) irqs <= irqs + 1;
		if (kei === 1'b1) keis <= keis + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// Delay moves at most 4 steps toward its target per crossing
	function automatic logic [9:0] ramp(input logic [9:0] cur, input logic [9:0] inten);
		int tg;
		tg = (inten >= 980) ? 0 : 980 - inten;
		if (tg > cur + 4) return cur + 4;
		if (tg + 4 < cur) return cur - 4;
		return tg[9:0];
	endfunction : ramp

	// One mains crossing, then a wait long enough for both pulses
	task automatic zc(input logic on, input logic [9:0] inten);
		int n, k0;
		@(negedge clk);
		dim_on = on;
		intensity = inten;
		zc_sel = 2'($random(seed));
		go = 1'b1;
		rq.delete();
		fq.delete();
		irqs = 0;
		keis = 0;
		@(negedge clk);
		go = 1'b0;
		n = 0;
		while (kei !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		k0 = cyc;
		chk(kei, 1'b1);
		if (on) dly = ramp(dly, inten);
		@(negedge clk);
		chk(firing_delay, dly);
		repeat (2050 * S) @(negedge clk);
		chk(keis, 1);
		chk(rq.size(), on ? 2 : 0);
		chk(irqs, on ? 4 : 0);
		if (on) begin
			chk(rq[0] - k0, (dly + 1) * S);
			chk(fq[0] - rq[0], 10 * S);
			chk(rq[1] - rq[0], 1000 * S);
			chk(fq[1] - rq[1], 10 * S);
		end
		$display("crossing done on=%0d delay=%0d", on, dly);
	endtask : zc

	// Tick delay, optionally frozen by the enable for g cycles
	task automatic ms(input logic [15:0] u, input int g);
		int n, c0;
		@(negedge clk);
		ms_units = u;
		ms_start = 1'b1;
		@(negedge clk);
		ms_start = 1'b0;
		c0 = cyc;
		chk({ms_busy, ms_wrap_flag}, 2'b10);
		if (g > 0) begin
			en = 1'b0;
			repeat (g) @(negedge clk);
			en = 1'b1;
		end
		n = 0;
		while (ms_done !== 1'b1 && n < (u + 2) * M + g + 8) begin
			@(negedge clk);
			n++;
		end
		chk(ms_done, 1'b1);
		chk(cyc - c0, 1 + (u == 0 ? 1 : u) * M + g);
		chk({ms_wrap_flag, ms_busy}, 2'b10);
		$display("tick delay done units=%0d", u);
	endtask : ms

	// Main sequence: reset, crossings, tick delays
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		chk(firing_delay, 10'h03D4);
		chk(triac_gate, 1'b0);
		zc(1'b1, 10'h03FF);
		zc(1'b0, 10'($random(seed)));
		zc(1'b1, 10'h0000);
		repeat (3) zc(1'b1, 10'($random(seed)));
		ms(16'h0003, 0);
		ms(16'h0000, 5);
		ms(16'($random(seed) & 7), 0);
		test_done();
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule : zero_cross_phase_dimmer_bench
